// File: hw/srlc_divider.sv
// srlc_divider: latch clock pulse generator
// assumes the select is stable or that a change may shorten one period
`timescale 1ns/1ps
`default_nettype none
module srlc_divider (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [2:0] sel,
	// one-cycle pulse
	output logic tick
);
	import srlc_pkg::*;

	logic [SRLC_DIV_W-1:0] cnt_r;
	logic [SRLC_DIV_W-1:0] mask;

	// mask of low counter bits for the chosen power of two
	function automatic logic [SRLC_DIV_W-1:0] div_mask(input logic [2:0] s);
		logic [SRLC_DIV_W:0] one;
		one = '0;
		one[SRLC_DIV_BASE_LOG2 + int'(s)] = 1'b1;
		return SRLC_DIV_W'(one - 1'b1);
	endfunction

	assign mask = div_mask(sel);

	// free counter; stopped while disabled so phase restarts cleanly
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (!run) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else begin
			tick <= run && ((cnt_r & mask) == mask);
		end
	end
endmodule
`default_nettype wire

// File: hw/srlc_latch.sv
// srlc_latch: the set/reset latch core, reset dominant
// assumes set and reset inputs are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module srlc_latch (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// latch inputs
	input wire logic enable,
	input wire logic set_in,
	input wire logic reset_in,
	// state
	output logic q
);
	// reset wins when both are active, a safe default
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else if (!enable) begin
			q <= 1'b0;
		end else if (reset_in) begin
			q <= 1'b0;
		end else if (set_in) begin
			q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: hw/srlc_pkg.sv
// srlc_pkg: constants and types for the set/reset latch control block
// assumes one 10 MHz system clock and a byte-wide software register port
package srlc_pkg;
	localparam int SRLC_ADDR_W = 4;
	localparam int SRLC_DATA_W = 8;
	// register offset (index) of the single control register
	localparam logic [SRLC_ADDR_W-1:0] SRLC_CTRL_OFS = 4'h0;
	// status register: latch state and outputs
	localparam logic [SRLC_ADDR_W-1:0] SRLC_STAT_OFS = 4'h1;
	localparam logic [SRLC_DATA_W-1:0] SRLC_CTRL_RST = 8'h00;
	// field positions
	localparam int SRLC_EN_BIT = 7;
	localparam int SRLC_DIV_HI = 6;
	localparam int SRLC_DIV_LO = 4;
	localparam int SRLC_QEN_BIT = 3;
	localparam int SRLC_NQEN_BIT = 2;
	localparam int SRLC_PS_BIT = 1;
	localparam int SRLC_PR_BIT = 0;
	// divider: code 0 divides by 4, each code doubles
	localparam int SRLC_DIV_W = 9;
	localparam int SRLC_DIV_BASE_LOG2 = 2;
	// pulse length of a software set/reset, in system cycles
	localparam int SRLC_PULSE_CYC = 1;

	typedef struct packed {
		logic latch_enable;
		logic [2:0] latch_clock_divider_select;
		logic true_output_enable;
		logic inverted_output_enable;
		logic pulse_set_request;
		logic pulse_reset_request;
	} srlc_ctrl_t;

	typedef struct packed {
		logic [SRLC_ADDR_W-1:0] addr;
		logic [SRLC_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} srlc_bus_t;

	typedef struct packed {
		logic latch_true_pin;
		logic latch_inverted_pin;
		logic latch_true_pin_oe_n;
		logic latch_inverted_pin_oe_n;
	} srlc_pins_t;
endpackage

// File: hw/srlc_top.sv
// srlc_top: control register and pin logic for the set/reset latch
// assumes a byte register port on clk_sys; external set/reset come in
// on ext_set/ext_reset from other logic on the same clock
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The latch runs only when the enable bit is 1; at 0 no output reaches a pin.
// - A 3-bit select picks the latch clock pulse period as a power of two cycles.
// - Code 000 divides by 4 and each higher code doubles, up to 512 at 111.
// - Each latch clock pulse is exactly one system cycle wide.
// - With the latch enabled and true enable 1 the true output drives its pin.
// - With the latch enabled and inverted enable 1 the inverted output drives its pin.
// - Writing 1 to pulse-set pulses the set input for one system cycle; 0 does nothing.
// - Writing 1 to pulse-reset pulses the reset input for one system cycle; 0 does nothing.
module srlc_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [srlc_pkg::SRLC_ADDR_W-1:0] reg_addr,
	input wire logic [srlc_pkg::SRLC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [srlc_pkg::SRLC_DATA_W-1:0] reg_rdata,
	// other latch sources, already gated by their own selects
	input wire logic ext_set,
	input wire logic ext_reset,
	// latch clock pulse for the set/reset source selects
	output logic latch_clock_tick,
	// pins
	output srlc_pkg::srlc_pins_t pins
);
	import srlc_pkg::*;

	srlc_ctrl_t ctrl_r;
	logic [SRLC_DATA_W-1:0] rdata_nxt;
	logic set_pulse_r;
	logic reset_pulse_r;
	logic q;
	logic tick;
	logic wr_ctrl;

	assign wr_ctrl = reg_wr && (reg_addr == SRLC_CTRL_OFS);

	// control bits in one process, so the struct has a single driver
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r.latch_enable <= SRLC_CTRL_RST[SRLC_EN_BIT];
			ctrl_r.latch_clock_divider_select <=
				SRLC_CTRL_RST[SRLC_DIV_HI:SRLC_DIV_LO];
			ctrl_r.true_output_enable <= SRLC_CTRL_RST[SRLC_QEN_BIT];
			ctrl_r.inverted_output_enable <= SRLC_CTRL_RST[SRLC_NQEN_BIT];
			ctrl_r.pulse_set_request <= SRLC_CTRL_RST[SRLC_PS_BIT];
			ctrl_r.pulse_reset_request <= SRLC_CTRL_RST[SRLC_PR_BIT];
		end else begin
			if (wr_ctrl) begin
				ctrl_r.latch_enable <= reg_wdata[SRLC_EN_BIT];
				ctrl_r.latch_clock_divider_select <=
					reg_wdata[SRLC_DIV_HI:SRLC_DIV_LO];
				ctrl_r.true_output_enable <= reg_wdata[SRLC_QEN_BIT];
				ctrl_r.inverted_output_enable <= reg_wdata[SRLC_NQEN_BIT];
			end
			// set-only, cleared once the pulse went out
			// a new write of 1 wins over the hardware clear
			ctrl_r.pulse_set_request <= wr_ctrl && reg_wdata[SRLC_PS_BIT];
			ctrl_r.pulse_reset_request <= wr_ctrl && reg_wdata[SRLC_PR_BIT];
		end
	end

	// one-period pulses; writing 0 has no effect
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			set_pulse_r <= 1'b0;
			reset_pulse_r <= 1'b0;
		end else begin
			set_pulse_r <= wr_ctrl && reg_wdata[SRLC_PS_BIT];
			reset_pulse_r <= wr_ctrl && reg_wdata[SRLC_PR_BIT];
		end
	end

	srlc_divider u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(ctrl_r.latch_enable),
		.sel(ctrl_r.latch_clock_divider_select),
		.tick(tick)
	);

	assign latch_clock_tick = tick;

	srlc_latch u_latch (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.enable(ctrl_r.latch_enable),
		.set_in(set_pulse_r | ext_set),
		.reset_in(reset_pulse_r | ext_reset),
		.q(q)
	);

	// pin drive, enables low while driving
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '{1'b0, 1'b1, 1'b1, 1'b1};
		end else begin
			pins.latch_true_pin <= q;
			pins.latch_inverted_pin <= ~q;
			pins.latch_true_pin_oe_n <=
				!(ctrl_r.latch_enable && ctrl_r.true_output_enable);
			pins.latch_inverted_pin_oe_n <=
				!(ctrl_r.latch_enable && ctrl_r.inverted_output_enable);
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_nxt = '0;
		case (reg_addr)
			SRLC_CTRL_OFS: rdata_nxt = ctrl_r;
			SRLC_STAT_OFS: rdata_nxt = {5'h00, tick, ~q, q};
			default: rdata_nxt = '0;
		endcase
	end

	// read data valid the cycle after the strobe only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// File: tb/srlc_top_monitor.sv
// srlc_mon: port-level checks on srlc_top
// assumes every port of srlc_top sits on the one clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module srlc_mon (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [srlc_pkg::SRLC_ADDR_W-1:0] reg_addr,
	input wire logic [srlc_pkg::SRLC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [srlc_pkg::SRLC_DATA_W-1:0] reg_rdata,
	// latch side
	input wire logic ext_set,
	input wire logic ext_reset,
	input wire logic latch_clock_tick,
	input wire srlc_pkg::srlc_pins_t pins
);
	import srlc_pkg::*;
	logic [7:0] ctl_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// shadow of the control byte; pulse bits unused here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= 8'h00;
		end else if (reg_wr && reg_addr == SRLC_CTRL_OFS) begin
			ctl_r <= reg_wdata;
		end
	end
	// enable already on, so the pulse is not masked
	sequence s_pset;
		reg_wr && reg_addr == SRLC_CTRL_OFS && reg_wdata[7] && ctl_r[7]
			&& reg_wdata[1:0] == 2'h2 && !ext_reset;
	endsequence
	sequence s_prst;
		reg_wr && reg_addr == SRLC_CTRL_OFS && reg_wdata[7] && ctl_r[7]
			&& reg_wdata[0] && !ext_set;
	endsequence
	a_tick_one: assert property (
		latch_clock_tick |=> !latch_clock_tick [*3])
		else $error("tick too wide or too close");
	a_true_oe: assert property (
		pins.latch_true_pin_oe_n == !($past(ctl_r[7]) && $past(ctl_r[3])))
		else $error("true pin enable wrong");
	a_inv_oe: assert property (
		pins.latch_inverted_pin_oe_n == !($past(ctl_r[7]) && $past(ctl_r[2])))
		else $error("inverted pin enable wrong");
	a_off_low: assert property (
		!ctl_r[7] && !$past(ctl_r[7]) && !$past(ctl_r[7], 2)
		|-> !pins.latch_true_pin)
		else $error("latch runs while disabled");
	a_pset_q: assert property (s_pset |-> ##3 pins.latch_true_pin)
		else $error("pulse set missed");
	a_prst_q: assert property (s_prst |-> ##3 !pins.latch_true_pin)
		else $error("pulse reset missed");
	a_pins_inv: assert property (
		pins.latch_true_pin != pins.latch_inverted_pin)
		else $error("outputs not complementary");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule
bind srlc_top srlc_mon mon_u (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_set(ext_set),
	.ext_reset(ext_reset), .latch_clock_tick(latch_clock_tick), .pins(pins));
`default_nettype wire

// File: tb/tb.sv
// tb: self-checking bench for srlc_top
// assumes srlc_mon is bound in from its own file
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", s, e, g); end end
module tb;
	import srlc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ext_set = 1'b0;
	logic ext_reset = 1'b0;
	logic [7:0] reg_rdata;
	logic latch_clock_tick;
	srlc_pins_t pins;
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	srlc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_set(ext_set), .ext_reset(ext_reset),
		.latch_clock_tick(latch_clock_tick), .pins(pins));
	always #50 clk_sys = ~clk_sys;
	// one bus cycle; strobes stay until the next op
	task op(input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		op(1'b0, 1'b1, a, 8'h00);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CHK("rdata", e, reg_rdata)
		@(posedge clk_sys);
	endtask
	// pins as {true, inverted, true_oe_n, inverted_oe_n}
	task pin_chk(input logic [3:0] e);
		repeat (4) op(1'b0, 1'b0, 4'h0, 8'h00);
		@(negedge clk_sys);
		`CHK("pins", e, pins)
		@(posedge clk_sys);
	endtask
	// cycles until the next tick, capped so a dead divider cannot hang
	task gap;
		n = 0;
		@(negedge clk_sys);
		while (latch_clock_tick !== 1'b1 && n < 1100) begin
			@(negedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
	endtask
	task s_map;
		rd(SRLC_CTRL_OFS, SRLC_CTRL_RST);
		pin_chk(4'h7);
		op(1'b1, 1'b0, 4'h2, 8'hff);
		rd(4'h2, 8'h00);
		rd(SRLC_CTRL_OFS, 8'h00);
	endtask
	task s_pulse;
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8c);
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8e);
		rd(SRLC_CTRL_OFS, 8'h8e);
		rd(SRLC_CTRL_OFS, 8'h8c);
		pin_chk(4'h8);
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8d);
		pin_chk(4'h4);
		ext_set <= 1'b1;
		op(1'b0, 1'b0, 4'h0, 8'h00);
		ext_set <= 1'b0;
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8c);
		pin_chk(4'h8);
		ext_reset <= 1'b1;
		op(1'b0, 1'b0, 4'h0, 8'h00);
		ext_reset <= 1'b0;
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8c);
		pin_chk(4'h4);
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h88);
		pin_chk(4'h5);
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h84);
		pin_chk(4'h6);
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8e);
		pin_chk(4'h8);
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h8f);
		pin_chk(4'h4);
	endtask
	// first gap may straddle the select change
	task s_div;
		for (int i = 0; i < 8; i++) begin
			op(1'b1, 1'b0, SRLC_CTRL_OFS, {1'b1, i[2:0], 4'h0});
			op(1'b0, 1'b0, 4'h0, 8'h00);
			gap();
			gap();
			gap();
			`CHK("period", 4 << i, n + 1)
		end
	endtask
	task s_off;
		op(1'b1, 1'b0, SRLC_CTRL_OFS, 8'h6c);
		ext_set <= 1'b1;
		pin_chk(4'h7);
		ext_set <= 1'b0;
		rd(SRLC_STAT_OFS, 8'h02);
		gap();
		`CHK("no tick", 1100, n)
	endtask
	task end_sim;
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		s_map();
		s_pulse();
		s_div();
		s_off();
		end_sim();
	end
	initial begin
		#2000000;
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
